// ==== fpet_timer.sv ====
// Purpose: Program and erase phase timer of an on-chip flash controller
// Assumes: Commands are taken only while idle; data arrives per location
// Notes:   Durations are counted in flash timing clock ticks
`timescale 1ns/1ps
`include "fpet_defs.svh"
module fpet_timer
  import fpet_pkg::*;
(
  // Clock and reset
  input  wire logic                   mclk_in,
  input  wire logic                   rst_in,
  // Timing clock setup
  input  wire logic [`FPET_DIV_W-1:0] tick_div_in,
  // Command
  input  wire logic                   start_in,
  input  wire fpet_cmd_e              cmd_in,
  input  wire logic                   blk_more_in,
  input  wire logic                   blk_last_in,
  // Flash array controls
  output logic                        prog_out,
  output logic                        erase_out,
  output logic                        mass_out,
  output logic                        next_loc_out,
  // Status
  output logic                        busy_out,
  output logic                        done_out,
  output logic [5:0]                  blk_index_out,
  output logic                        range_err_out
);
  fpet_state_e state;
  fpet_cnt_t   cnt;
  logic        tick;
  logic        run;
  logic        phase_end;

  assign run = (state != FPET_IDLE) && (state != FPET_BLK_WAIT);

  fpet_tick_div u_div (
    .mclk_in       (mclk_in),
    .rst_in        (rst_in),
    .run_in        (run),
    .div_in        (tick_div_in),
    .tick_out      (tick),
    .range_err_out (range_err_out)
  );

  function automatic fpet_cnt_t load_of(input fpet_state_e s);
    unique case (s)
      FPET_WORD:      load_of = `FPET_WORD_TICKS;
      FPET_BLK_FIRST: load_of = `FPET_BLK0_TICKS;
      FPET_BLK_NEXT:  load_of = `FPET_BLKN_TICKS;
      FPET_BLK_END:   load_of = `FPET_BLKEND_TICKS;
      default:        load_of = '0;
    endcase
  endfunction

  assign phase_end = tick && (cnt == `FPET_CNT_W'(1));

  // Sequencer; counter reloads with each phase entry
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= FPET_IDLE;
      cnt   <= '0;
    end else begin
      unique case (state)
        FPET_IDLE: begin
          if (start_in) begin
            unique case (cmd_in)
              FPET_CMD_WORD: begin
                state <= FPET_WORD;
                cnt   <= load_of(FPET_WORD);
              end
              FPET_CMD_BLOCK: begin
                state <= FPET_BLK_FIRST;
                cnt   <= load_of(FPET_BLK_FIRST);
              end
              FPET_CMD_SEG: begin
                state <= FPET_ERASE;
                cnt   <= `FPET_SEG_TICKS;
              end
              FPET_CMD_MASS: begin
                state <= FPET_ERASE;
                cnt   <= `FPET_MASS_TICKS;
              end
              default: state <= FPET_IDLE;
            endcase
          end
        end
        FPET_BLK_FIRST, FPET_BLK_NEXT: begin
          if (phase_end) begin
            if (blk_last_in || blk_index_out == `FPET_BLK_LAST) begin
              state <= FPET_BLK_END;
              cnt   <= load_of(FPET_BLK_END);
            end else begin
              state <= FPET_BLK_WAIT;
            end
          end else if (tick) begin
            cnt <= cnt - `FPET_CNT_W'(1);
          end
        end
        // Stalls until next data is ready or block end is signalled; program voltage held off
        FPET_BLK_WAIT: begin
          if (blk_more_in) begin
            state <= FPET_BLK_NEXT;
            cnt   <= load_of(FPET_BLK_NEXT);
          end else if (blk_last_in) begin
            state <= FPET_BLK_END;
            cnt   <= load_of(FPET_BLK_END);
          end
        end
        FPET_WORD, FPET_BLK_END, FPET_ERASE: begin
          if (phase_end) begin
            state <= FPET_IDLE;
          end else if (tick) begin
            cnt <= cnt - `FPET_CNT_W'(1);
          end
        end
        default: state <= FPET_IDLE;
      endcase
    end
  end

  // Location index within a block
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      blk_index_out <= '0;
    end else if (state == FPET_IDLE) begin
      blk_index_out <= '0;
    end else if (state == FPET_BLK_WAIT && blk_more_in) begin
      blk_index_out <= blk_index_out + 6'h01;
    end
  end

  // Array controls and status from flops
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      mass_out <= 1'b0;
      done_out <= 1'b0;
      next_loc_out <= 1'b0;
    end else begin
      if (state == FPET_IDLE && start_in) begin
        mass_out <= (cmd_in == FPET_CMD_MASS);
      end
      done_out <= phase_end && (state == FPET_WORD ||
                  state == FPET_BLK_END || state == FPET_ERASE);
      next_loc_out <= phase_end && (state == FPET_BLK_FIRST ||
                      state == FPET_BLK_NEXT) && !blk_last_in &&
                      blk_index_out != `FPET_BLK_LAST;
    end
  end

  assign prog_out  = state == FPET_WORD || state == FPET_BLK_FIRST ||
                     state == FPET_BLK_NEXT;
  assign erase_out = state == FPET_ERASE;
  assign busy_out  = state != FPET_IDLE;

  // Ticks counted inside one phase
  logic [12:0] tk;
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      tk <= '0;
    end else if (state == FPET_IDLE || state == FPET_BLK_WAIT ||
                 phase_end) begin
      tk <= '0;
    end else if (tick) begin
      tk <= tk + 13'h0001;
    end
  end

  sequence s_word_start;
    state == FPET_IDLE && start_in && cmd_in == FPET_CMD_WORD;
  endsequence

  chk_word_ticks: assert property (@(posedge mclk_in) disable iff (rst_in)
    (state == FPET_WORD && phase_end) |-> tk == 13'h0022)
    else $error("word program tick count wrong");
  chk_blk_first: assert property (@(posedge mclk_in) disable iff (rst_in)
    (state == FPET_BLK_FIRST && phase_end) |-> tk == 13'h001d)
    else $error("first block location tick count wrong");
  chk_blk_next: assert property (@(posedge mclk_in) disable iff (rst_in)
    (state == FPET_BLK_NEXT && phase_end) |-> tk == 13'h0014)
    else $error("further block location tick count wrong");
  chk_blk_end: assert property (@(posedge mclk_in) disable iff (rst_in)
    (state == FPET_BLK_END && phase_end) |-> tk == 13'h0005)
    else $error("block end wait tick count wrong");
  chk_mass_ticks: assert property (@(posedge mclk_in) disable iff (rst_in)
    (erase_out && mass_out && phase_end) |-> tk == 13'h14b0)
    else $error("mass erase tick count wrong");
  chk_seg_ticks: assert property (@(posedge mclk_in) disable iff (rst_in)
    (erase_out && !mass_out && phase_end) |-> tk == 13'h12d2)
    else $error("segment erase tick count wrong");
  sequence s_erase_start;
    state == FPET_IDLE && start_in &&
    (cmd_in == FPET_CMD_SEG || cmd_in == FPET_CMD_MASS);
  endsequence

  chk_busy_start: assert property (@(posedge mclk_in) disable iff (rst_in)
    s_word_start |=> (busy_out && prog_out) [*2])
    else $error("busy not raised at word start");
  chk_erase_start: assert property (@(posedge mclk_in) disable iff (rst_in)
    s_erase_start |=> (busy_out && erase_out && !prog_out) [*2])
    else $error("erase condition not raised at erase start");
  chk_loc_pulse: assert property (@(posedge mclk_in) disable iff (rst_in)
    next_loc_out |-> state == FPET_BLK_WAIT && !prog_out)
    else $error("next location pulse outside block wait");
  chk_wait_resume: assert property (@(posedge mclk_in) disable iff (rst_in)
    (state == FPET_BLK_WAIT && blk_more_in) |=> prog_out && busy_out)
    else $error("block location not resumed after data ready");
  chk_done_pulse: assert property (@(posedge mclk_in) disable iff (rst_in)
    done_out |=> !done_out)
    else $error("done pulse longer than one cycle");
  chk_busy_done: assert property (@(posedge mclk_in) disable iff (rst_in)
    done_out |-> !busy_out && $past(busy_out))
    else $error("busy not dropped at completion");
endmodule

// ==== fpet_defs.svh ====
// Purpose: Constants for the flash program/erase timer
// Assumes: Durations counted in flash timing clock periods
// Notes:   Included by the package and by both design modules
`ifndef FPET_DEFS_SVH
`define FPET_DEFS_SVH

`define FPET_CNT_W        13
`define FPET_WORD_TICKS   13'h0023
`define FPET_BLK0_TICKS   13'h001e
`define FPET_BLKN_TICKS   13'h0015
`define FPET_BLKEND_TICKS 13'h0006
`define FPET_MASS_TICKS   13'h14b1
`define FPET_SEG_TICKS    13'h12d3
`define FPET_BLK_LAST     6'h3f
`define FPET_DIV_W        8
`define FPET_DIV_DEFAULT  8'h3c
`define FPET_DIV_MIN      8'h35
`define FPET_DIV_MAX      8'h61

`endif

// ==== fpet_pkg.sv ====
// Purpose: Types for the flash program/erase timer
// Assumes: fpet_defs.svh holds all numbers
// Notes:   Command codes and sequencer states
`include "fpet_defs.svh"
package fpet_pkg;
  typedef enum logic [2:0] {
    FPET_CMD_WORD,
    FPET_CMD_BLOCK,
    FPET_CMD_SEG,
    FPET_CMD_MASS,
    FPET_CMD_NONE
  } fpet_cmd_e;

  typedef enum logic [2:0] {
    FPET_IDLE,
    FPET_WORD,
    FPET_BLK_FIRST,
    FPET_BLK_NEXT,
    FPET_BLK_WAIT,
    FPET_BLK_END,
    FPET_ERASE
  } fpet_state_e;

  typedef logic [`FPET_CNT_W-1:0] fpet_cnt_t;
endpackage

// ==== fpet_tick_div.sv ====
// Purpose: Divides the system clock into flash timing clock enable pulses
// Assumes: Divider value chosen by the issuing party
// Notes:   Out-of-band ratios are flagged, not blocked
`timescale 1ns/1ps
`include "fpet_defs.svh"
module fpet_tick_div
  import fpet_pkg::*;
(
  // Clock and reset
  input  wire logic                   mclk_in,
  input  wire logic                   rst_in,
  // Control
  input  wire logic                   run_in,
  input  wire logic [`FPET_DIV_W-1:0] div_in,
  // Tick
  output logic                        tick_out,
  output logic                        range_err_out
);
  logic [`FPET_DIV_W-1:0] cnt;

  // Restarting at each operation keeps the first period whole
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt <= '0;
    end else if (!run_in || cnt == div_in - `FPET_DIV_W'(1)) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + `FPET_DIV_W'(1);
    end
  end

  assign tick_out = run_in && (cnt == div_in - `FPET_DIV_W'(1));

  // Band 257..476 kHz at 25 MHz means a ratio of 53..97
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      range_err_out <= 1'b0;
    end else begin
      range_err_out <= (div_in < `FPET_DIV_MIN) ||
                       (div_in > `FPET_DIV_MAX);
    end
  end
endmodule

// ==== fpet_flash_model.sv ====
// Purpose: Far-side block data source for the flash timer
// Assumes: Next location, or block end at the chosen index, offered one cycle after each request
// Notes:   Ends the block at a chosen index, never past 63
`timescale 1ns/1ps
module fpet_flash_model
  import fpet_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk_in,
  input  wire logic       rst_in,
  // From timer
  input  wire logic       next_loc_in,
  input  wire logic       done_in,
  input  wire logic [5:0] blk_index_in,
  input  wire logic [5:0] last_idx_in,
  // To timer
  output logic            blk_more_out,
  output logic            blk_last_out
);
  // Capping locations per block bounds the summed program time
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      blk_more_out <= 1'b0;
      blk_last_out <= 1'b0;
    end else if (next_loc_in) begin
      blk_more_out <= (blk_index_in != last_idx_in);
      blk_last_out <= (blk_index_in == last_idx_in);
    end else begin
      blk_more_out <= 1'b0;
      if (done_in) begin
        blk_last_out <= 1'b0;
      end
    end
  end
endmodule

// ==== fpet_timer_tb.sv ====
// Purpose: Self-checking bench for the flash program/erase timer
// Assumes: Divider 53 in band, briefly 1 to time whole erases
// Notes:   In-band erases are cut by reset; full erases use a fast divider
`timescale 1ns/1ps
module fpet_timer_tb;
  import fpet_pkg::*;
  localparam int D = 53;
  logic mclk_in = 1'b0, rst_in = 1'b1, start_in = 1'b0;
  fpet_cmd_e cmd_in = FPET_CMD_NONE;
  logic [7:0] tick_div_in = D[7:0];
  logic blk_more_in, blk_last_in, prog_out, erase_out, mass_out;
  logic next_loc_out, busy_out, done_out, range_err_out;
  logic [5:0] blk_index_out;
  int error_cnt = 0, samples_checked = 0, cyc = 0;
  always #20 mclk_in = ~mclk_in;
  fpet_timer i_fpet_timer (.mclk_in(mclk_in), .rst_in(rst_in),
    .tick_div_in(tick_div_in), .start_in(start_in), .cmd_in(cmd_in),
    .blk_more_in(blk_more_in), .blk_last_in(blk_last_in),
    .prog_out(prog_out), .erase_out(erase_out), .mass_out(mass_out),
    .next_loc_out(next_loc_out), .busy_out(busy_out), .done_out(done_out),
    .blk_index_out(blk_index_out), .range_err_out(range_err_out));
  fpet_flash_model i_fpet_flash_model (.mclk_in(mclk_in), .rst_in(rst_in),
    .next_loc_in(next_loc_out), .done_in(done_out),
    .blk_index_in(blk_index_out), .last_idx_in(6'h02),
    .blk_more_out(blk_more_in), .blk_last_out(blk_last_in));
  task automatic results;
    if (error_cnt == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t exp %h got %h", $time, exp, got);
    end
  endtask
  // Request held until the taking edge, released at that edge
  task automatic go(input fpet_cmd_e c);
    @(posedge mclk_in);
    start_in <= 1'b1;
    cmd_in <= c;
    @(posedge mclk_in);
    start_in <= 1'b0;
    cmd_in <= FPET_CMD_NONE;
  endtask
  task automatic wt(input bit loc, output int n);
    n = 0;
    do begin
      @(posedge mclk_in);
      #1;
      n++;
    end while (!(loc ? next_loc_out === 1'b1 : done_out === 1'b1)
               && n < 9000);
  endtask
  task automatic t_word;
    int n;
    go(FPET_CMD_WORD);
    @(posedge mclk_in);
    start_in <= 1'b1;
    cmd_in <= FPET_CMD_SEG;
    @(posedge mclk_in);
    start_in <= 1'b0;
    #1;
    chk(1, busy_out & prog_out & ~erase_out);
    chk(0, range_err_out);
    wt(0, n);
    chk(35 * D, n + 2);
    chk(0, busy_out | prog_out | erase_out);
  endtask
  task automatic t_block;
    int n;
    go(FPET_CMD_BLOCK);
    wt(1, n);
    chk(30 * D, n);
    chk(0, blk_index_out);
    wt(1, n);
    chk(21 * D + 2, n);
    chk(1, blk_index_out);
    wt(1, n);
    chk(21 * D + 2, n);
    repeat (3) @(posedge mclk_in);
    #1;
    chk(1, busy_out & ~prog_out);
    wt(0, n);
    chk(6 * D - 1, n);
  endtask
  // Out-of-band divider is flagged, yet still times whole erases quickly
  task automatic t_fast;
    int n;
    @(posedge mclk_in);
    tick_div_in <= 8'h01;
    repeat (2) @(posedge mclk_in);
    #1;
    chk(1, range_err_out);
    repeat (2) begin
      go(FPET_CMD_MASS);
      wt(0, n);
      chk(5297, n);
      chk(1, mass_out);
    end
    go(FPET_CMD_SEG);
    wt(0, n);
    chk(4819, n);
    chk(0, mass_out);
    @(posedge mclk_in);
    tick_div_in <= D[7:0];
    repeat (2) @(posedge mclk_in);
    #1;
    chk(0, range_err_out);
  endtask
  task automatic t_erase(input fpet_cmd_e c, input logic m);
    go(c);
    repeat (2) @(posedge mclk_in);
    #1;
    chk(1, busy_out & erase_out & ~prog_out);
    chk(m, mass_out);
    // Outlasting every program phase shows the erase is the long count
    repeat (36 * D) @(posedge mclk_in);
    #1;
    chk(1, busy_out & erase_out & ~done_out);
    @(posedge mclk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    rst_in <= 1'b0;
    #1;
    chk(0, busy_out | erase_out | done_out);
  endtask
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      results;
    end
  end
  initial begin
    repeat (20) @(posedge mclk_in);
    rst_in <= 1'b0;
    t_word;
    t_block;
    t_erase(FPET_CMD_SEG, 1'b0);
    t_erase(FPET_CMD_MASS, 1'b1);
    t_fast;
    results;
  end
endmodule
